/* File: verilog/mpl_regs.svh */
`ifndef MPL_REGS_SVH
`define MPL_REGS_SVH

// System clock rate
`define MPL_CLK_MHZ 125

// Nominal bit period and its clock count
`define MPL_BIT_PERIOD_NS 14300
`define MPL_BIT_CYC ((`MPL_BIT_PERIOD_NS * `MPL_CLK_MHZ) / 1000)

// Bit rate range and allowed deviation within one frame
`define MPL_SLOW_KBPS 32
`define MPL_FAST_KBPS 80
`define MPL_DEV_PCT 11
`define MPL_PER_MAX_CYC ((((`MPL_CLK_MHZ * 1000) / `MPL_SLOW_KBPS) * (100 + `MPL_DEV_PCT)) / 100)
`define MPL_PER_MIN_CYC ((((`MPL_CLK_MHZ * 1000) / `MPL_FAST_KBPS) * (100 - `MPL_DEV_PCT)) / 100)

// Access deadline after power-up
`define MPL_UNLOCK_MS 8
`define MPL_UNLOCK_CYC (`MPL_UNLOCK_MS * `MPL_CLK_MHZ * 1000)

// Reply start delay, typical and latest
`define MPL_REPLY_TYP_US 50
`define MPL_REPLY_CYC (`MPL_REPLY_TYP_US * `MPL_CLK_MHZ)
`define MPL_REPLY_MAX_US 150
`define MPL_REPLY_MAX_CYC (`MPL_REPLY_MAX_US * `MPL_CLK_MHZ)

// Setup before the first programming strobe
`define MPL_STROBE_SETUP_US 40
`define MPL_STROBE_SETUP_CYC (`MPL_STROBE_SETUP_US * `MPL_CLK_MHZ)

// Gap after a frame, in bit periods
`define MPL_GAP_BITS 2

// Check value preset and customer access command
`define MPL_CRC_INIT 3'h7
`define MPL_ACCESS_ADDR 6'h24
`define MPL_ACCESS_DATA 30'h27811f77

// Frame layout: bits after sync, and bit indices within whole frames
`define MPL_WR_BITS 6'h28
`define MPL_RD_BITS 6'h0a
`define MPL_SYNC_BITS 6'h02
`define MPL_WR_LAST 6'h29
`define MPL_RD_LAST 6'h0b
`define MPL_REPLY_CRC_IDX 6'h20
`define MPL_REPLY_LAST 6'h22

`endif

/* File: verilog/mpl_pkg.sv */
package mpl_pkg;

  typedef enum logic [6:0] {
    D_IDLE  = 7'h01,
    D_SYNC  = 7'h02,
    D_MEAS  = 7'h04,
    D_BLANK = 7'h08,
    D_SEEK  = 7'h10,
    D_WAIT  = 7'h20,
    D_TX    = 7'h40
  } mpl_dev_state_t;

  typedef enum logic [5:0] {
    H_IDLE = 6'h01,
    H_TX   = 6'h02,
    H_RXW  = 6'h04,
    H_RX   = 6'h08,
    H_NV   = 6'h10,
    H_GAP  = 6'h20
  } mpl_host_state_t;

  // One serial step of the x^3 + x + 1 check register
  function automatic logic [2:0] mpl_crc_step(input logic [2:0] crc, input logic b);
    logic fb;
    fb = crc[2] ^ b;
    return {crc[1], crc[0] ^ fb, fb};
  endfunction : mpl_crc_step

endpackage : mpl_pkg

/* File: verilog/mpl_if.sv */
`timescale 1ns/1ps
interface mpl_if;
  // Supply line level, high is idle
  logic supply_line;
  // Output line level and Manchester drive enable of the device
  logic out_line;
  logic out_oe;

  modport dev (input supply_line, output out_line, output out_oe);
  modport host (output supply_line, input out_line, input out_oe);
endinterface : mpl_if

/* File: verilog/mpl_device.sv */
`timescale 1ns/1ps
`include "mpl_regs.svh"

// Overview of operation
// - Read request suspends normal output, sends reply
// - Normal output resumes; controller waits two bits
// - Three-bit check using x^3 + x + 1
// - Check skips the two sync bits
// - Check value is the last three bits
// - Check register preset to 111 per frame
// - Bad check value discards the command silently
// - Access command sent within 8 ms of power-up
// - Rate 32 to 80 kbps, reply follows it
// - Bit period may drift 11 percent per frame
// - Two bit gap after volatile write
// - Two bit gap after second programming strobe
// - Reply starts 50 us minus quarter bit
// - 40 us before first programming strobe
// - Supply returns to idle within 15 us
// - Falling mid-bit means one, rising means zero
// - Nominal bit period 14.3 us at 70 kbps
// - Frame: sync, direction, address, data, check
// - Reply data 23:0, error status 25:24
// - Only reads get a reply frame
// - MSB first; missed deadline locks access
module mpl_device
  import mpl_pkg::*;
#(
  parameter int UNLOCK_CYC = `MPL_UNLOCK_CYC,
  parameter int REPLY_DELAY_CYC = `MPL_REPLY_CYC,
  parameter int PER_MIN_CYC = `MPL_PER_MIN_CYC,
  parameter int PER_MAX_CYC = `MPL_PER_MAX_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Link to the controller
  mpl_if.dev link,
  // Field-dependent output while no reply runs
  input wire logic normal_out,
  // Accepted write commands
  output logic wr_valid,
  output logic [5:0] wr_addr,
  output logic [29:0] wr_data,
  // Read requests and the data that answers them
  output logic rd_req,
  output logic [5:0] rd_addr,
  input wire logic [23:0] rd_data,
  input wire logic [1:0] rd_ecc,
  // Access status
  output logic unlocked,
  output logic locked_out
);

  mpl_dev_state_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] per_q, per_d;
  logic [5:0] nbits_q, nbits_d;
  logic [39:0] rx_q, rx_d;
  logic [2:0] crc_q, crc_d;
  logic prev_q;
  logic unl_q, unl_d;
  logic dead_q, dead_d;
  logic [31:0] age_q, age_d;
  logic [29:0] tx_q, tx_d;
  logic [5:0] bit_period_q, bit_period_d;
  logic cur_q, cur_d;
  logic oe_q, oe_d;
  logic line_q, line_d;
  logic wr_valid_q, wr_valid_d;
  logic [5:0] wr_addr_q, wr_addr_d;
  logic [29:0] wr_data_q, wr_data_d;
  logic rd_req_q, rd_req_d;
  logic [5:0] rd_addr_q, rd_addr_d;
  logic rise, fall;
  logic [15:0] blank_lim, end_lim;
  logic is_wr, is_rd, is_acc;

  // Edges on the supply line; the line is taken as synchronous
  assign rise = link.supply_line & ~prev_q;
  assign fall = ~link.supply_line & prev_q;
  // Blank 3/4 bit after a mid-bit edge to skip boundary edges, which keeps 11 percent drift safe
  assign blank_lim = per_q - (per_q >> 2);
  assign end_lim = per_q + (per_q >> 1);

  // Frame classification on the collected bits
  assign is_wr = (nbits_q == `MPL_WR_BITS) && !rx_q[39];
  assign is_rd = (nbits_q == `MPL_RD_BITS) && rx_q[9];
  assign is_acc = (rx_q[38:33] == `MPL_ACCESS_ADDR) && (rx_q[32:3] == `MPL_ACCESS_DATA);

  // Next state of the receive, reply and access logic
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + 16'h0001;
    per_d = per_q;
    nbits_d = nbits_q;
    rx_d = rx_q;
    crc_d = crc_q;
    unl_d = unl_q;
    dead_d = dead_q;
    age_d = age_q;
    tx_d = tx_q;
    bit_period_d = bit_period_q;
    cur_d = cur_q;
    oe_d = oe_q;
    wr_valid_d = 1'b0;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    rd_req_d = 1'b0;
    rd_addr_d = rd_addr_q;
    // Deadline counter; once missed, access stays locked until reset
    if (!unl_q && !dead_q) begin
      age_d = age_q + 32'h0000_0001;
      if (age_q >= 32'(UNLOCK_CYC - 1)) begin
        dead_d = 1'b1;
      end
    end
    case (state_q)
      D_IDLE: begin
        cnt_d = 16'h0000;
        if (fall) begin
          state_d = D_SYNC;
        end
      end
      // First sync bit: wait for its rising mid-bit edge
      D_SYNC: begin
        if (rise) begin
          cnt_d = 16'h0000;
          state_d = D_MEAS;
        end else if (cnt_q >= 16'(PER_MAX_CYC)) begin
          state_d = D_IDLE;
        end
      end
      // Mid of sync bit 0 to mid of sync bit 1 is one bit period
      D_MEAS: begin
        if (rise) begin
          per_d = cnt_q + 16'h0001;
          cnt_d = 16'h0000;
          nbits_d = 6'h00;
          crc_d = `MPL_CRC_INIT;
          state_d = (cnt_q < 16'(PER_MIN_CYC)) ? D_IDLE : D_BLANK;
        end else if (cnt_q >= 16'(PER_MAX_CYC)) begin
          state_d = D_IDLE;
        end
      end
      D_BLANK: begin
        if (cnt_q >= blank_lim) begin
          state_d = D_SEEK;
        end
      end
      // Next edge is the mid-bit one; its direction is the bit
      D_SEEK: begin
        if (rise || fall) begin
          rx_d = {rx_q[38:0], fall};
          crc_d = mpl_crc_step(crc_q, fall);
          nbits_d = (nbits_q == 6'h3f) ? nbits_q : nbits_q + 6'h01;
          cnt_d = 16'h0000;
          state_d = D_BLANK;
        end else if (cnt_q >= end_lim) begin
          // Silence past 1.5 bits ends the frame; check value bits drive the register to zero
          state_d = D_IDLE;
          if (crc_q == 3'h0) begin
            if (is_wr && is_acc && !dead_q) begin
              unl_d = 1'b1;
            end else if (is_wr && unl_q) begin
              wr_valid_d = 1'b1;
              wr_addr_d = rx_q[38:33];
              wr_data_d = rx_q[32:3];
            end else if (is_rd && unl_q) begin
              rd_req_d = 1'b1;
              rd_addr_d = rx_q[8:3];
              cnt_d = 16'h0000;
              state_d = D_WAIT;
            end
          end
        end
      end
      // Frame end was seen one bit late, so take that and a quarter bit off the delay
      D_WAIT: begin
        if (32'(cnt_q) + 32'(per_q) + 32'(per_q >> 2) >= 32'(REPLY_DELAY_CYC)) begin
          tx_d = {4'h0, rd_ecc, rd_data};
          bit_period_d = 6'h00;
          cur_d = 1'b0;
          crc_d = `MPL_CRC_INIT;
          cnt_d = 16'h0000;
          oe_d = 1'b1;
          state_d = D_TX;
        end
      end
      // Reply at the measured period: sync, data MSB first, check value
      D_TX: begin
        if (cnt_q >= per_q - 16'h0001) begin
          cnt_d = 16'h0000;
          bit_period_d = bit_period_q + 6'h01;
          if (bit_period_q == `MPL_REPLY_LAST) begin
            oe_d = 1'b0;
            state_d = D_IDLE;
          end else if (bit_period_q + 6'h01 < `MPL_SYNC_BITS) begin
            cur_d = 1'b0;
          end else if (bit_period_q + 6'h01 < `MPL_REPLY_CRC_IDX) begin
            cur_d = tx_q[29];
            tx_d = {tx_q[28:0], 1'b0};
            crc_d = mpl_crc_step(crc_q, tx_q[29]);
          end else begin
            cur_d = crc_q[2];
            crc_d = {crc_q[1:0], 1'b0};
          end
        end
      end
      default: begin
        state_d = D_IDLE;
      end
    endcase
    // First half carries the bit, so a one falls at mid-bit
    if (oe_d) begin
      line_d = (cnt_d < (per_q >> 1)) ? cur_d : ~cur_d;
    end else begin
      line_d = normal_out;
    end
  end

  // Register all state
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= D_IDLE;
      cnt_q <= 16'h0000;
      per_q <= 16'h0000;
      nbits_q <= 6'h00;
      rx_q <= 40'h00_0000_0000;
      crc_q <= `MPL_CRC_INIT;
      prev_q <= 1'b1;
      unl_q <= 1'b0;
      dead_q <= 1'b0;
      age_q <= 32'h0000_0000;
      tx_q <= 30'h0000_0000;
      bit_period_q <= 6'h00;
      cur_q <= 1'b0;
      oe_q <= 1'b0;
      line_q <= 1'b0;
      wr_valid_q <= 1'b0;
      wr_addr_q <= 6'h00;
      wr_data_q <= 30'h0000_0000;
      rd_req_q <= 1'b0;
      rd_addr_q <= 6'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      per_q <= per_d;
      nbits_q <= nbits_d;
      rx_q <= rx_d;
      crc_q <= crc_d;
      prev_q <= link.supply_line;
      unl_q <= unl_d;
      dead_q <= dead_d;
      age_q <= age_d;
      tx_q <= tx_d;
      bit_period_q <= bit_period_d;
      cur_q <= cur_d;
      oe_q <= oe_d;
      line_q <= line_d;
      wr_valid_q <= wr_valid_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
      rd_req_q <= rd_req_d;
      rd_addr_q <= rd_addr_d;
    end
  end

  // Outputs straight from flip-flops
  assign link.out_line = line_q;
  assign link.out_oe = oe_q;
  assign wr_valid = wr_valid_q;
  assign wr_addr = wr_addr_q;
  assign wr_data = wr_data_q;
  assign rd_req = rd_req_q;
  assign rd_addr = rd_addr_q;
  assign unlocked = unl_q;
  assign locked_out = dead_q;

endmodule : mpl_device

/* File: verilog/mpl_host.sv */
`timescale 1ns/1ps
`include "mpl_regs.svh"

// Command queue; depth is assumed to be a power of two
module mpl_fifo #(
  parameter int WIDTH = 38,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic push, pop;

  // Extra pointer bit tells full from empty
  assign in_ready = (wp_q[AW] == rp_q[AW]) || (wp_q[AW-1:0] != rp_q[AW-1:0]);
  assign out_valid = (wp_q != rp_q);
  assign out_data = mem_q[rp_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer advance
  always_comb begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
  end

  // Pointers and storage
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule : mpl_fifo

module mpl_host
  import mpl_pkg::*;
#(
  parameter int BIT_CYC = `MPL_BIT_CYC,
  parameter int REPLY_TIMEOUT_CYC = `MPL_REPLY_MAX_CYC,
  parameter int STROBE_SETUP_CYC = `MPL_STROBE_SETUP_CYC,
  parameter int STROBE_CYC = 12500,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Link to the device
  mpl_if.host link,
  // Command requests
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic cmd_nv,
  input wire logic [5:0] cmd_addr,
  input wire logic [29:0] cmd_data,
  // Read answers
  output logic rsp_valid,
  output logic rsp_ok,
  output logic rsp_timeout,
  output logic [1:0] rsp_ecc,
  output logic [23:0] rsp_data,
  // Programming strobe request to the high-voltage driver
  output logic hv_strobe,
  output logic busy
);
  mpl_host_state_t state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic [5:0] idx_q, idx_d, last_q, last_d;
  logic [36:0] fr_q, fr_d;
  logic [2:0] crc_q, crc_d;
  logic cur_q, cur_d, rd_q, rd_d, nv_q, nv_d, acc_q, acc_d;
  logic line_q, line_d;
  logic [1:0] ph_q, ph_d;
  logic [29:0] rdat_q, rdat_d;
  logic rv_q, rv_d, rok_q, rok_d, rto_q, rto_d;
  logic q_valid, q_ready;
  logic [37:0] q_data;

  mpl_fifo #(.WIDTH(38), .DEPTH(DEPTH)) i_mpl_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data({cmd_nv, cmd_read, cmd_addr, cmd_data}),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );

  // Queue drains only between transactions, so a busy link backs up into cmd_ready
  assign q_ready = (state_q == H_IDLE) && acc_q;

  // Next state of the frame engine
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + 32'h0000_0001;
    idx_d = idx_q;
    last_d = last_q;
    fr_d = fr_q;
    crc_d = crc_q;
    cur_d = cur_q;
    rd_d = rd_q;
    nv_d = nv_q;
    acc_d = acc_q;
    ph_d = ph_q;
    rdat_d = rdat_q;
    rv_d = 1'b0;
    rok_d = rok_q;
    rto_d = rto_q;
    case (state_q)
      // Access command goes out first after reset, well inside the deadline
      H_IDLE: begin
        cnt_d = 32'h0000_0000;
        if (!acc_q || q_valid) begin
          acc_d = 1'b1;
          fr_d = acc_q ? q_data[36:0] : {1'b0, `MPL_ACCESS_ADDR, `MPL_ACCESS_DATA};
          rd_d = acc_q && q_data[36];
          nv_d = acc_q && q_data[37] && !q_data[36];
          last_d = (acc_q && q_data[36]) ? `MPL_RD_LAST : `MPL_WR_LAST;
          idx_d = 6'h00;
          cur_d = 1'b0;
          crc_d = `MPL_CRC_INIT;
          state_d = H_TX;
        end
      end
      H_TX: begin
        if (cnt_q >= 32'(BIT_CYC - 1)) begin
          cnt_d = 32'h0000_0000;
          idx_d = idx_q + 6'h01;
          if (idx_q == last_q) begin
            // Line is back at idle from the next cycle on
            state_d = rd_q ? H_RXW : (nv_q ? H_NV : H_GAP);
            ph_d = 2'h0;
          end else if (idx_q + 6'h01 < `MPL_SYNC_BITS) begin
            cur_d = 1'b0;
          end else if (idx_q + 6'h01 < last_q - 6'h02) begin
            cur_d = fr_q[36];
            fr_d = {fr_q[35:0], 1'b0};
            crc_d = mpl_crc_step(crc_q, fr_q[36]);
          end else begin
            cur_d = crc_q[2];
            crc_d = {crc_q[1:0], 1'b0};
          end
        end
      end
      H_RXW: begin
        if (link.out_oe) begin
          cnt_d = 32'h0000_0000;
          idx_d = 6'h00;
          crc_d = `MPL_CRC_INIT;
          state_d = H_RX;
        end else if (cnt_q >= 32'(REPLY_TIMEOUT_CYC)) begin
          rv_d = 1'b1;
          rok_d = 1'b0;
          rto_d = 1'b1;
          cnt_d = 32'h0000_0000;
          state_d = H_GAP;
        end
      end
      // Sample the first half of each bit after sync at a quarter period
      H_RX: begin
        if (cnt_q == 32'(BIT_CYC / 4) && idx_q >= `MPL_SYNC_BITS) begin
          crc_d = mpl_crc_step(crc_q, link.out_line);
          if (idx_q < `MPL_REPLY_CRC_IDX) begin
            rdat_d = {rdat_q[28:0], link.out_line};
          end
        end
        if (cnt_q >= 32'(BIT_CYC - 1)) begin
          cnt_d = 32'h0000_0000;
          idx_d = idx_q + 6'h01;
          if (idx_q == `MPL_REPLY_LAST) begin
            rv_d = 1'b1;
            rok_d = (crc_q == 3'h0);
            rto_d = 1'b0;
            state_d = H_GAP;
          end
        end
      end
      // Setup, strobe, space, strobe
      H_NV: begin
        if (cnt_q >= ((ph_q == 2'h0) ? 32'(STROBE_SETUP_CYC) : 32'(STROBE_CYC)) - 32'h0000_0001) begin
          cnt_d = 32'h0000_0000;
          ph_d = ph_q + 2'h1;
          if (ph_q == 2'h3) begin
            state_d = H_GAP;
          end
        end
      end
      H_GAP: begin
        if (cnt_q >= 32'(`MPL_GAP_BITS * BIT_CYC - 1)) begin
          state_d = H_IDLE;
        end
      end
      default: begin
        state_d = H_IDLE;
      end
    endcase
    // Idle high; a one is high in its first half
    if (state_d == H_TX) begin
      line_d = (cnt_d < 32'(BIT_CYC / 2)) ? cur_d : ~cur_d;
    end else begin
      line_d = 1'b1;
    end
  end

  // Register all state
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= H_IDLE;
      cnt_q <= 32'h0000_0000;
      idx_q <= 6'h00;
      last_q <= 6'h00;
      fr_q <= 37'h00_0000_0000;
      crc_q <= `MPL_CRC_INIT;
      cur_q <= 1'b0;
      rd_q <= 1'b0;
      nv_q <= 1'b0;
      acc_q <= 1'b0;
      line_q <= 1'b1;
      ph_q <= 2'h0;
      rdat_q <= 30'h0000_0000;
      rv_q <= 1'b0;
      rok_q <= 1'b0;
      rto_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      last_q <= last_d;
      fr_q <= fr_d;
      crc_q <= crc_d;
      cur_q <= cur_d;
      rd_q <= rd_d;
      nv_q <= nv_d;
      acc_q <= acc_d;
      line_q <= line_d;
      ph_q <= ph_d;
      rdat_q <= rdat_d;
      rv_q <= rv_d;
      rok_q <= rok_d;
      rto_q <= rto_d;
    end
  end

  assign link.supply_line = line_q;
  assign rsp_valid = rv_q;
  assign rsp_ok = rok_q;
  assign rsp_timeout = rto_q;
  assign rsp_ecc = rdat_q[25:24];
  assign rsp_data = rdat_q[23:0];
  assign hv_strobe = (state_q == H_NV) && ph_q[0];
  assign busy = (state_q != H_IDLE) || !acc_q;

endmodule : mpl_host

/* File: verif/mpl_link_monitor.sv */
`timescale 1ns/1ps
module mpl_link_monitor #(
  parameter int BIT_CYC = 1787,
  parameter int REPLY_DELAY_CYC = 6250
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Link lines
  input wire logic supply_line,
  input wire logic out_line,
  input wire logic out_oe
);
  localparam int HALF_LO = BIT_CYC / 2 - 2;
  localparam int HALF_HI = BIT_CYC / 2 + 2;
  localparam int FULL_LO = BIT_CYC - 2;
  localparam int FULL_HI = BIT_CYC + 2;
  localparam int DLY_LO = REPLY_DELAY_CYC - BIT_CYC / 2 - 8;
  localparam int DLY_HI = REPLY_DELAY_CYC + BIT_CYC / 2 + 8;
  localparam int LEN_LO = 35 * BIT_CYC - 40;
  localparam int LEN_HI = 35 * BIT_CYC + 40;
  logic [19:0] quiet_q, quiet_d, len_q, len_d, run_q, run_d, since_q, since_d;
  logic sup_q, line_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // Run lengths saturate so long idle spans never wrap into a false short gap
  always_comb begin
    quiet_d = (supply_line != sup_q) ? 20'h0 : quiet_q + {19'h0, quiet_q != 20'hfffff};
    run_d = (out_line != line_q) ? 20'h0 : run_q + {19'h0, run_q != 20'hfffff};
    len_d = out_oe ? len_q + 20'h1 : 20'h0;
    since_d = out_oe ? 20'h0 : since_q + {19'h0, since_q != 20'hfffff};
  end

  // Register the helper counters
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      quiet_q <= 20'hfffff;
      run_q <= 20'h0;
      len_q <= 20'h0;
      since_q <= 20'hfffff;
      sup_q <= 1'b1;
      line_q <= 1'b0;
    end else begin
      quiet_q <= quiet_d;
      run_q <= run_d;
      len_q <= len_d;
      since_q <= since_d;
      sup_q <= supply_line;
      line_q <= out_line;
    end
  end

  a_host_bit_edges: assert property ($changed(supply_line) && quiet_q < FULL_HI + BIT_CYC / 4 |->
    (quiet_q inside {[HALF_LO:HALF_HI]} || quiet_q inside {[FULL_LO:FULL_HI]}))
    else $error("supply edge off the half-bit grid");
  a_frame_gap_min: assert property ($fell(supply_line) && quiet_q > FULL_HI + BIT_CYC / 4 |->
    quiet_q >= 2 * BIT_CYC)
    else $error("command frame started too soon");
  a_low_run_bound: assert property ($rose(supply_line) |-> quiet_q <= FULL_HI)
    else $error("supply held low too long");
  a_gap_after_reply: assert property ($fell(supply_line) |-> since_q >= 2 * BIT_CYC)
    else $error("command started too soon after reply");
  a_host_quiet_reply: assert property (out_oe |-> supply_line)
    else $error("supply moved during reply");
  a_reply_start_delay: assert property ($rose(out_oe) |-> quiet_q inside {[DLY_LO:DLY_HI]})
    else $error("reply start delay out of range");
  a_reply_frame_len: assert property ($fell(out_oe) |-> len_q inside {[LEN_LO:LEN_HI]})
    else $error("reply frame length wrong");
  a_reply_half_bit: assert property ($changed(out_line) && out_oe && $past(out_oe) |-> run_q >= HALF_LO)
    else $error("reply edge closer than half a bit");
  a_reply_sync_low: assert property ($rose(out_oe) |=> !out_line [*8])
    else $error("reply does not open with a zero");

  // Main scenarios
  c_reply_start: cover property ($rose(out_oe));
  c_reply_end: cover property ($fell(out_oe));
  c_frame_start: cover property ($fell(supply_line) && quiet_q > 2 * BIT_CYC);
endmodule : mpl_link_monitor

/* File: verif/tb_manchester_program_link.sv */
`timescale 1ns/1ps
module tb_manchester_program_link;
  localparam int BIT = 500;
  localparam int DLY = 2000;
  logic clk_sys, reset_n, normal_out, cmd_valid, cmd_ready, cmd_read, cmd_nv, wr_valid, busy, hv_strobe;
  logic rsp_valid, rsp_ok, rsp_timeout, rd_req, unlocked, locked_out, rsp_seen, oe_prev;
  logic [5:0] cmd_addr, rd_addr, wr_addr;
  logic [29:0] cmd_data, wr_data;
  logic [23:0] rd_data, rsp_data;
  logic [1:0] rd_ecc, rsp_ecc;
  logic [34:0] got, exp;
  int n_fail, n_compared, n_acc, n_reply;

  mpl_if ifc();

  // Period limits are narrowed so a short bit keeps the whole run brief
  mpl_device #(.UNLOCK_CYC(80000), .REPLY_DELAY_CYC(DLY), .PER_MIN_CYC(400), .PER_MAX_CYC(800)) i_mpl_device (
    .clk_sys(clk_sys), .reset_n(reset_n), .link(ifc), .normal_out(normal_out), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_ecc(rd_ecc), .unlocked(unlocked), .locked_out(locked_out));

  mpl_host #(.BIT_CYC(BIT), .REPLY_TIMEOUT_CYC(6000), .STROBE_SETUP_CYC(50), .STROBE_CYC(20)) i_mpl_host (
    .clk_sys(clk_sys), .reset_n(reset_n), .link(ifc), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_read(cmd_read), .cmd_nv(cmd_nv), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_ok(rsp_ok), .rsp_timeout(rsp_timeout), .rsp_ecc(rsp_ecc), .rsp_data(rsp_data), .hv_strobe(hv_strobe),
    .busy(busy));

  mpl_link_monitor #(.BIT_CYC(BIT), .REPLY_DELAY_CYC(DLY)) i_mpl_link_monitor (.clk_sys(clk_sys),
    .reset_n(reset_n), .supply_line(ifc.supply_line), .out_line(ifc.out_line), .out_oe(ifc.out_oe));

  // Reference check value, written apart from the design's own step
  function automatic logic [2:0] crc_of(input logic [29:0] v);
    logic [2:0] c;
    logic fb;
    c = 3'h7;
    for (int i = 29; i >= 0; i--) begin
      fb = c[2] ^ v[i];
      c = {c[1], c[0] ^ fb, fb};
    end
    return c;
  endfunction : crc_of

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    n_compared++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic tally_and_finish();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Answers may land while the reply is still being sampled, so latch them
  always @(posedge clk_sys) begin
    rsp_seen <= rsp_seen | (rsp_valid === 1'b1);
    if (ifc.out_oe === 1'b1 && !oe_prev) n_reply++;
    oe_prev <= (ifc.out_oe === 1'b1);
  end

  // Hang guard
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_fail++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    reset_n = 1'b0;
    normal_out = 1'b1;
    cmd_valid = 1'b0;
    cmd_read = 1'b1;
    cmd_nv = 1'b0;
    cmd_addr = 6'h2b;
    cmd_data = 30'h0;
    rd_data = 24'h5a3c81;
    rd_ecc = 2'h2;
    rsp_seen = 1'b0;
    oe_prev = 1'b0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    do @(posedge clk_sys); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    @(posedge clk_sys iff rd_req === 1'b1);
    #1;
    check(rd_addr, 6'h2b);
    check({unlocked, locked_out}, 2'h2);
    check(ifc.out_line, 1'b1);
    // Sample each reply bit a quarter bit in, where its first-half level stands
    @(posedge clk_sys iff ifc.out_oe === 1'b1);
    repeat (BIT / 4) @(posedge clk_sys);
    for (int k = 34; k >= 0; k--) begin
      got[k] = ifc.out_line;
      repeat (BIT) @(posedge clk_sys);
    end
    exp = {2'h0, 4'h0, rd_ecc, rd_data, crc_of({4'h0, rd_ecc, rd_data})};
    check(got, exp);
    wait (rsp_seen === 1'b1);
    #1;
    check({rsp_ok, rsp_timeout}, 2'h2);
    check({rsp_ecc, rsp_data}, {rd_ecc, rd_data});
    @(posedge clk_sys);
    normal_out <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check({ifc.out_oe, ifc.out_line}, 2'h0);
    check(n_reply, 1);
    // Fill the queue while the host sits in its post-reply gap
    @(posedge clk_sys);
    cmd_read <= 1'b0;
    cmd_nv <= 1'b1;
    cmd_addr <= 6'h01;
    cmd_data <= 30'h2abc_1234;
    cmd_valid <= 1'b1;
    n_acc = 0;
    while (n_acc < 40) begin
      @(posedge clk_sys);
      if (cmd_ready !== 1'b1) break;
      n_acc++;
    end
    cmd_valid <= 1'b0;
    check(n_acc, 16);
    // Strobes follow the frame end, before the device has seen the frame close
    @(posedge clk_sys iff hv_strobe === 1'b1);
    n_acc = 0;
    while (hv_strobe === 1'b1) begin
      @(posedge clk_sys);
      n_acc++;
    end
    check(n_acc, 20);
    @(posedge clk_sys iff wr_valid === 1'b1);
    #1;
    check({wr_addr, wr_data}, {6'h01, 30'h2abc_1234});
    reset_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    check({ifc.supply_line, ifc.out_oe, cmd_ready, unlocked, busy, hv_strobe}, 6'h2a);
    tally_and_finish();
  end
endmodule : tb_manchester_program_link
